// *** hdl/dfp_bcd_adder.sv ***
// Purpose: Eight-digit BCD adder, subtracting through the nines complement
// Assumes: Operands hold valid BCD digits
// Notes: For subtract set add_cin; add_cout high then means no borrow
`timescale 1ns/1ps
module dfp_bcd_adder (
	dfp_dp_if.adder dp
);
	// Ripple digit by digit with decimal adjust
	always_comb begin
		logic [4:0] s;
		logic [3:0] bd;
		logic c;
		s = 5'h00;
		bd = 4'h0;
		c = dp.add_cin;
		dp.add_sum = 32'h0000_0000;
		for (int i = 0; i < 8; i++) begin
			bd = dp.add_sub ? dfp_pkg::NINE - dp.add_b[i*4 +: 4] : dp.add_b[i*4 +: 4];
			s = {1'b0, dp.add_a[i*4 +: 4]} + {1'b0, bd} + {4'h0, c};
			c = s > dfp_pkg::DIGIT_MAX;
			if (c)
				s = s + dfp_pkg::DEC_ADJUST; // Skip the six unused codes
			dp.add_sum[i*4 +: 4] = s[3:0];
		end
		dp.add_cout = c;
	end
endmodule

// *** hdl/dfp_dp_if.sv ***
// Purpose: Operand and result wires between the core and its digit datapath
// Assumes: Purely combinational consumers on the same clock
// Notes: One modport per party
`timescale 1ns/1ps
interface dfp_dp_if;
	logic [31:0] add_a;
	logic [31:0] add_b;
	logic [31:0] add_sum;
	logic add_sub;
	logic add_cin;
	logic add_cout;
	logic stp_es;
	logic [7:0] stp_em;
	logic stp_up;
	logic stp_es_o;
	logic [7:0] stp_em_o;
	logic stp_wrap;

	modport core (output add_a, add_b, add_sub, add_cin, stp_es, stp_em, stp_up,
		input add_sum, add_cout, stp_es_o, stp_em_o, stp_wrap);
	modport adder (input add_a, add_b, add_sub, add_cin, output add_sum, add_cout);
	modport stepper (input stp_es, stp_em, stp_up, output stp_es_o, stp_em_o, stp_wrap);
endinterface

// *** hdl/dfp_exp_stepper.sv ***
// Purpose: Step a signed BCD exponent by one with wrap at the limits
// Assumes: Input exponent is within plus or minus 99
// Notes: stp_wrap tells the core to set the overflow toggle
`timescale 1ns/1ps
module dfp_exp_stepper (
	dfp_dp_if.stepper dp
);
	// Increment or decrement, then repack with wrap
	always_comb begin
		dfp_pkg::dfp_exp_t v;
		v = dfp_pkg::exp_val(dp.stp_es, dp.stp_em);
		v = dp.stp_up ? v + 9'sh001 : v - 9'sh001;
		{dp.stp_wrap, dp.stp_es_o, dp.stp_em_o} = dfp_pkg::exp_wrap(v);
	end
endmodule

// *** hdl/dfp_float_unit.sv ***
// Purpose: Decimal float add, subtract, multiply and divide on accumulator and aux
// Assumes: Sequencer holds op inputs valid with start and waits for done
// Notes: One digit shift per cycle; a start without the float bit is ignored
`timescale 1ns/1ps

// Function
// - Multiply forms a sixteen-digit signed fraction product across accumulator and aux
// - Multiply: accumulator exponent is exponent sum, aux exponent is sum minus eight
// - Divide normalizes divisor, then shifts dividend right once if needed
// - Divide exponents difference and minus eight; quotient to acc, remainder to aux
// - Each right shift increments exponent; past +99 wraps to -99, toggle set
// - Each normalizing left shift decrements exponent; past -99 wraps to +99, toggle
// - Normalized add/sub: zero fraction becomes positive zero with exponent -99
// - Add/sub: negative zero exponent becomes positive when fraction is nonzero
// - Add/sub never alter the six preserved bit positions in the accumulator; aux takes the memory word's
// - Add/sub load the memory word into aux, then compare exponents signed
// - Unnormalized, difference above eight: larger operand, signed, is the result
// - Within eight: shift smaller right to match, add five to last digit out
// - Addition overflow: shift right unrounded, one into top digit, exponent plus one
// - Unlike-sign add subtracts aux from acc; underflow flips sign, runs complement
// - Subtract subtracts on like signs, adds on unlike, otherwise as add
// - Normalized, difference above fifteen: larger operand becomes result, then normalized
// - Normalized, within eight: arithmetic as unnormalized, then result normalized
// - Normalized, nine to fifteen: prenormalize larger, recheck, then proceed as fitting
// - Normalize-select bit one picks normalized forms, zero picks unnormalized
// - Operations run in floating mode only when the float-select bit is one
// - Operands are a signed decimal fraction times a signed power of ten
module dfp_float_unit (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] op,
	input wire logic normalize_select_bit,
	input wire logic float_select_bit,
	input wire dfp_pkg::dfp_word_t mem_word,
	input wire logic acc_load,
	input wire dfp_pkg::dfp_word_t acc_in,
	input wire logic ovf_clear,
	output dfp_pkg::dfp_word_t acc_word,
	output dfp_pkg::dfp_word_t aux_word,
	output logic busy,
	output logic done,
	output logic float_overflow_toggle
);
	typedef enum logic [14:0] {
		S_IDLE = 15'h0001, S_PREP = 15'h0002, S_CMP = 15'h0004, S_PRENORM = 15'h0008,
		S_ALIGN = 15'h0010, S_ROUND = 15'h0020, S_ARITH = 15'h0040, S_COMP = 15'h0080,
		S_NORM = 15'h0100, S_FIN = 15'h0200, S_MUL = 15'h0400, S_DIVN = 15'h0800,
		S_DIVCHK = 15'h1000, S_DIV = 15'h2000, S_DIVFIN = 15'h4000
	} dfp_state_t;

	dfp_state_t st, next_st;
	dfp_pkg::dfp_word_t a, next_a, r, next_r, mc, next_mc;
	logic [3:0] cnt, next_cnt, hd, next_hd, qd, next_qd, last, next_last;
	logic shf, next_shf, sel_r, next_sel_r, pren, next_pren, nrm, next_nrm;
	logic sub, next_sub, next_busy, next_done, ovf, next_ovf, set_ovf;
	dfp_pkg::dfp_exp_t ea, er, ed, d, ad, v;
	logic [9:0] pk;
	logic eff_add;
	dfp_pkg::dfp_word_t opnd;

	dfp_dp_if dp();
	dfp_bcd_adder u_add (.dp(dp.adder));
	dfp_exp_stepper u_stp (.dp(dp.stepper));

	// Zero cleanup; nz low skips the zero rewrite
	function automatic dfp_pkg::dfp_word_t clean(input dfp_pkg::dfp_word_t w,
		input logic nz);
		if (w.frac != 32'h0000_0000 && w.esign && w.exp == 8'h00)
			w.esign = 1'b0;
		if (nz && w.frac == 32'h0000_0000) begin
			w.fsign = 1'b0;
			w.esign = 1'b1;
			w.exp = dfp_pkg::EXP_MAG_MAX;
		end
		return w;
	endfunction

	// Signed exponents and their distance, shared by all states
	always_comb begin
		ea = dfp_pkg::exp_val(a.esign, a.exp);
		er = dfp_pkg::exp_val(r.esign, r.exp);
		ed = dfp_pkg::exp_val(mc.esign, mc.exp);
		d = ea - er;
		ad = (d < 0) ? -d : d;
		eff_add = a.fsign == (r.fsign ^ sub);
		opnd = sel_r ? r : a;
	end

	// Adder and stepper operand select by state
	always_comb begin
		dp.add_a = a.frac;
		dp.add_b = mc.frac;
		dp.add_sub = 1'b0;
		dp.add_cin = 1'b0;
		dp.stp_es = a.esign;
		dp.stp_em = a.exp;
		dp.stp_up = 1'b1;
		case (st)
			S_ARITH: begin
				dp.add_b = r.frac;
				dp.add_sub = !eff_add;
				dp.add_cin = !eff_add;
			end
			S_ROUND: begin
				dp.add_a = opnd.frac;
				dp.add_b = 32'h0000_0000;
				dp.add_cin = 1'b1;
			end
			S_COMP: begin
				dp.add_a = 32'h0000_0000;
				dp.add_b = a.frac;
				dp.add_sub = 1'b1;
				dp.add_cin = 1'b1;
			end
			S_DIVCHK, S_DIV: begin
				dp.add_sub = 1'b1;
				dp.add_cin = 1'b1;
			end
			S_PRENORM, S_ALIGN: begin
				dp.stp_es = opnd.esign;
				dp.stp_em = opnd.exp;
				dp.stp_up = st == S_ALIGN;
			end
			S_NORM: dp.stp_up = 1'b0;
			S_DIVN: begin
				dp.stp_es = mc.esign;
				dp.stp_em = mc.exp;
				dp.stp_up = 1'b0;
			end
			default: dp.add_cin = 1'b0;
		endcase
	end

	// Sequencer next state
	always_comb begin
		next_st = st;
		next_a = a;
		next_r = r;
		next_mc = mc;
		next_cnt = cnt;
		next_hd = hd;
		next_qd = qd;
		next_last = last;
		next_shf = shf;
		next_sel_r = sel_r;
		next_pren = pren;
		next_nrm = nrm;
		next_sub = sub;
		next_busy = busy;
		next_done = 1'b0;
		set_ovf = 1'b0;
		v = ea;
		pk = 10'h000;
		case (st)
			S_IDLE: begin
				if (acc_load)
					next_a = acc_in;
				if (start && float_select_bit) begin
					next_busy = 1'b1;
					next_nrm = normalize_select_bit;
					next_sub = op == dfp_pkg::OP_SUB;
					next_pren = 1'b0;
					next_shf = 1'b0;
					next_cnt = 4'h0;
					next_hd = 4'h0;
					next_last = 4'h0;
					next_st = S_PREP;
					if (op != dfp_pkg::OP_DIV)
						next_r = mem_word;
					if (op == dfp_pkg::OP_MUL) begin
						next_mc = a;
						next_a.frac = 32'h0000_0000;
						next_a.fsign = a.fsign ^ mem_word.fsign;
						next_r.fsign = a.fsign ^ mem_word.fsign;
						v = ea + dfp_pkg::exp_val(mem_word.esign, mem_word.exp);
						{set_ovf, next_a.esign, next_a.exp} = dfp_pkg::exp_wrap(v);
						pk = dfp_pkg::exp_wrap(v - dfp_pkg::AUX_EXP_OFFSET);
						{next_r.esign, next_r.exp} = pk[8:0];
						set_ovf = set_ovf | pk[9];
						next_qd = mem_word.frac[3:0];
						next_st = S_MUL;
					end else if (op == dfp_pkg::OP_DIV) begin
						next_mc = mem_word;
						next_st = S_DIVN;
					end
				end
			end
			S_PREP: begin
				next_a = clean(a, nrm);
				next_r = clean(r, nrm);
				next_st = S_CMP;
			end
			S_CMP: begin
				next_sel_r = d > 0;
				if (d == 0)
					next_st = S_ARITH;
				else if (ad <= dfp_pkg::ALIGN_LIMIT)
					next_st = S_ALIGN;
				else if (nrm && !pren && ad <= dfp_pkg::FAR_LIMIT) begin
					next_sel_r = d < 0;
					next_st = S_PRENORM;
				end else begin
					if (d < 0) begin
						next_a.frac = r.frac;
						next_a.fsign = r.fsign ^ sub;
						next_a.esign = r.esign;
						next_a.exp = r.exp;
					end
					next_st = nrm ? S_NORM : S_FIN;
				end
			end
			S_PRENORM: begin
				if (opnd.frac[31:28] != 4'h0 || opnd.frac == 32'h0000_0000) begin
					next_pren = 1'b1;
					next_st = S_CMP;
				end else begin
					set_ovf = dp.stp_wrap;
					if (sel_r)
						{next_r.esign, next_r.exp, next_r.frac} =
							{dp.stp_es_o, dp.stp_em_o, r.frac[27:0], 4'h0};
					else
						{next_a.esign, next_a.exp, next_a.frac} =
							{dp.stp_es_o, dp.stp_em_o, a.frac[27:0], 4'h0};
				end
			end
			S_ALIGN: begin
				if (ea == er)
					next_st = S_ROUND;
				else begin
					next_last = opnd.frac[3:0];
					next_shf = 1'b1;
					set_ovf = dp.stp_wrap;
					if (sel_r)
						{next_r.esign, next_r.exp, next_r.frac} =
							{dp.stp_es_o, dp.stp_em_o, 4'h0, r.frac[31:4]};
					else
						{next_a.esign, next_a.exp, next_a.frac} =
							{dp.stp_es_o, dp.stp_em_o, 4'h0, a.frac[31:4]};
				end
			end
			S_ROUND: begin
				// Five into the lost digit carries only when that digit was five or more
				if (shf && ({1'b0, last} + {1'b0, dfp_pkg::ROUND_DIGIT}) > dfp_pkg::DIGIT_MAX) begin
					if (sel_r)
						next_r.frac = dp.add_sum;
					else
						next_a.frac = dp.add_sum;
				end
				next_st = S_ARITH;
			end
			S_ARITH: begin
				next_a.frac = dp.add_sum;
				next_st = nrm ? S_NORM : S_FIN;
				if (eff_add && dp.add_cout) begin
					next_a.frac = {4'h1, dp.add_sum[31:4]};
					{next_a.esign, next_a.exp} = {dp.stp_es_o, dp.stp_em_o};
					set_ovf = dp.stp_wrap;
				end else if (!eff_add && !dp.add_cout) begin
					next_a.fsign = !a.fsign;
					next_st = S_COMP;
				end
			end
			S_COMP: begin
				next_a.frac = dp.add_sum;
				next_st = nrm ? S_NORM : S_FIN;
			end
			S_NORM: begin
				if (a.frac == 32'h0000_0000) begin
					next_a = clean(a, 1'b1);
					next_st = S_FIN;
				end else if (a.frac[31:28] == 4'h0) begin
					{next_a.esign, next_a.exp, next_a.frac} =
						{dp.stp_es_o, dp.stp_em_o, a.frac[27:0], 4'h0};
					set_ovf = dp.stp_wrap;
				end else
					next_st = S_FIN;
			end
			S_FIN: begin
				next_a = clean(a, 1'b0);
				next_done = 1'b1;
				next_busy = 1'b0;
				next_st = S_IDLE;
			end
			S_MUL: begin
				if (qd != 4'h0) begin
					next_a.frac = dp.add_sum;
					next_hd = hd + {3'h0, dp.add_cout};
					next_qd = qd - 4'h1;
				end else begin
					next_r.frac = {a.frac[3:0], r.frac[31:4]};
					next_a.frac = {hd, a.frac[31:4]};
					next_hd = 4'h0;
					next_qd = r.frac[7:4];
					next_cnt = cnt + 4'h1;
					if (cnt == dfp_pkg::LAST_DIGIT_IDX) begin
						next_done = 1'b1;
						next_busy = 1'b0;
						next_st = S_IDLE;
					end
				end
			end
			S_DIVN: begin
				if (mc.frac[31:28] == 4'h0 && mc.frac != 32'h0000_0000) begin
					{next_mc.esign, next_mc.exp, next_mc.frac} =
						{dp.stp_es_o, dp.stp_em_o, mc.frac[27:0], 4'h0};
					set_ovf = dp.stp_wrap;
				end else
					next_st = S_DIVCHK;
			end
			S_DIVCHK: begin
				// A nonzero divisor now has a nonzero top digit, so one shift suffices; a zero divisor leaves S_DIV looping
				if (dp.add_cout) begin
					next_r.frac = {a.frac[3:0], r.frac[31:4]};
					{next_a.esign, next_a.exp, next_a.frac} =
						{dp.stp_es_o, dp.stp_em_o, 4'h0, a.frac[31:4]};
					set_ovf = dp.stp_wrap;
				end
				next_st = S_DIV;
			end
			S_DIV: begin
				if (!shf) begin
					{next_hd, next_a.frac, next_r.frac} = {a.frac, r.frac, 4'h0};
					next_qd = 4'h0;
					next_shf = 1'b1;
				end else if (dp.add_cout || hd != 4'h0) begin
					next_a.frac = dp.add_sum;
					next_hd = dp.add_cout ? hd : hd - 4'h1;
					next_qd = qd + 4'h1;
				end else begin
					next_r.frac[3:0] = qd;
					next_shf = 1'b0;
					next_cnt = cnt + 4'h1;
					if (cnt == dfp_pkg::LAST_DIGIT_IDX)
						next_st = S_DIVFIN;
				end
			end
			S_DIVFIN: begin
				next_a.frac = r.frac;
				next_r.frac = a.frac;
				next_a.fsign = a.fsign ^ mc.fsign;
				next_r.fsign = a.fsign ^ mc.fsign;
				v = ea - ed;
				{set_ovf, next_a.esign, next_a.exp} = dfp_pkg::exp_wrap(v);
				pk = dfp_pkg::exp_wrap(v - dfp_pkg::AUX_EXP_OFFSET);
				{next_r.esign, next_r.exp} = pk[8:0];
				set_ovf = set_ovf | pk[9];
				next_done = 1'b1;
				next_busy = 1'b0;
				next_st = S_IDLE;
			end
			default: next_st = S_IDLE;
		endcase
		// Set beats a clear landing in the same cycle
		next_ovf = set_ovf ? 1'b1 : (ovf_clear ? 1'b0 : ovf);
	end

	// Register the whole state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_IDLE;
			a <= '0;
			r <= '0;
			mc <= '0;
			cnt <= 4'h0;
			hd <= 4'h0;
			qd <= 4'h0;
			last <= 4'h0;
			shf <= 1'b0;
			sel_r <= 1'b0;
			pren <= 1'b0;
			nrm <= 1'b0;
			sub <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			ovf <= 1'b0;
		end else begin
			st <= next_st;
			a <= next_a;
			r <= next_r;
			mc <= next_mc;
			cnt <= next_cnt;
			hd <= next_hd;
			qd <= next_qd;
			last <= next_last;
			shf <= next_shf;
			sel_r <= next_sel_r;
			pren <= next_pren;
			nrm <= next_nrm;
			sub <= next_sub;
			busy <= next_busy;
			done <= next_done;
			ovf <= next_ovf;
		end
	end

	assign acc_word = a;
	assign aux_word = r;
	assign float_overflow_toggle = ovf;
endmodule

// *** hdl/dfp_pkg.sv ***
// Purpose: Shared word layout, limits and exponent helpers for the decimal float unit
// Assumes: Fractions are eight BCD digits, exponents two BCD digits plus sign
// Notes: Exponent helpers are used by the core and by the exponent stepper
package dfp_pkg;

	// Word layout; keep holds the six positions that float add/sub never alter
	typedef struct packed {
		logic [5:0] keep;
		logic esign;
		logic [7:0] exp;
		logic fsign;
		logic [31:0] frac;
	} dfp_word_t;

	typedef logic signed [8:0] dfp_exp_t;

	// Limits and fixed figures
	localparam dfp_exp_t EXP_LIMIT = 9'sh063;
	localparam dfp_exp_t ALIGN_LIMIT = 9'sh008;
	localparam dfp_exp_t FAR_LIMIT = 9'sh00F;
	localparam dfp_exp_t AUX_EXP_OFFSET = 9'sh008;
	localparam dfp_exp_t RADIX = 9'sh00A;
	localparam logic [7:0] EXP_MAG_MAX = 8'h99;
	localparam logic [3:0] ROUND_DIGIT = 4'h5;
	localparam logic [3:0] NINE = 4'h9;
	localparam logic [4:0] DIGIT_MAX = 5'h09;
	localparam logic [4:0] DEC_ADJUST = 5'h06;
	localparam logic [3:0] LAST_DIGIT_IDX = 4'h7;

	// Operation codes
	localparam logic [1:0] OP_ADD = 2'h0;
	localparam logic [1:0] OP_SUB = 2'h1;
	localparam logic [1:0] OP_MUL = 2'h2;
	localparam logic [1:0] OP_DIV = 2'h3;

	// Signed value of a two-digit BCD exponent
	function automatic dfp_exp_t exp_val(input logic es, input logic [7:0] em);
		dfp_exp_t m;
		m = $signed({5'h00, em[7:4]}) * RADIX + $signed({5'h00, em[3:0]});
		return es ? -m : m;
	endfunction

	// Repack to {wrapped, sign, BCD}; past +99 gives -99, past -99 gives +99
	function automatic logic [9:0] exp_wrap(input dfp_exp_t v);
		dfp_exp_t m;
		m = (v < 0) ? -v : v;
		if (v > EXP_LIMIT)
			return {1'b1, 1'b1, EXP_MAG_MAX};
		if (v < -EXP_LIMIT)
			return {1'b1, 1'b0, EXP_MAG_MAX};
		return {1'b0, v < 0, 4'(m / RADIX), 4'(m % RADIX)};
	endfunction

endpackage

// *** sim/dfp_float_unit_properties.sv ***
// Purpose: Port-level temporal checks for the decimal float unit
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Operation details are latched at the accepted start for use at done
`timescale 1ns/1ps
module dfp_float_unit_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] op,
	input wire logic normalize_select_bit,
	input wire logic float_select_bit,
	input wire dfp_pkg::dfp_word_t mem_word,
	input wire logic acc_load,
	input wire dfp_pkg::dfp_word_t acc_in,
	input wire logic ovf_clear,
	input wire dfp_pkg::dfp_word_t acc_word,
	input wire dfp_pkg::dfp_word_t aux_word,
	input wire logic busy,
	input wire logic done,
	input wire logic float_overflow_toggle
);
	logic [1:0] sv_op;
	logic sv_norm;
	logic [5:0] sv_acc_keep;
	logic [5:0] sv_mem_keep;
	wire take = start && float_select_bit && !busy;
	wire sv_addsub = !sv_op[1];

	// Remember the accepted operation; done comes many cycles later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sv_op <= 2'h0;
			sv_norm <= 1'b0;
			sv_acc_keep <= 6'h00;
			sv_mem_keep <= 6'h00;
		end else if (take) begin
			sv_op <= op;
			sv_norm <= normalize_select_bit;
			sv_acc_keep <= acc_word.keep;
			sv_mem_keep <= mem_word.keep;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_take_busy; take |=> busy; endproperty
	a_take_busy: assert property (p_take_busy) else $error("accepted start left busy low");
	property p_ignore; start && !float_select_bit && !busy |=> !busy; endproperty
	a_ignore: assert property (p_ignore) else $error("start without float bit was taken");
	property p_idle_hold; !busy && !acc_load && !take |=> $stable(acc_word); endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("accumulator moved while idle");
	property p_keep_acc; done && sv_addsub |-> acc_word.keep == sv_acc_keep; endproperty
	a_keep_acc: assert property (p_keep_acc) else $error("accumulator kept bits altered");
	property p_keep_aux; done && sv_addsub |-> aux_word.keep == sv_mem_keep; endproperty
	a_keep_aux: assert property (p_keep_aux) else $error("aux kept bits differ from memory");
	property p_norm_zero;
		done && sv_addsub && sv_norm && acc_word.frac == 32'h0 |->
			acc_word.esign && acc_word.exp == 8'h99 && !acc_word.fsign;
	endproperty
	a_norm_zero: assert property (p_norm_zero) else $error("normalized zero not cleaned");
	property p_neg_zero;
		done && sv_addsub && acc_word.frac != 32'h0 |-> !(acc_word.esign && acc_word.exp == 8'h00);
	endproperty
	a_neg_zero: assert property (p_neg_zero) else $error("negative zero exponent left");
	property p_norm_top;
		done && sv_addsub && sv_norm && acc_word.frac != 32'h0 |-> acc_word.frac[31:28] != 4'h0;
	endproperty
	a_norm_top: assert property (p_norm_top) else $error("leading zero after normalize");
	// Multiply exponent wrap is decided in the accepting cycle, before busy rises
	property p_tog_rise; $rose(float_overflow_toggle) |-> $past(busy || take); endproperty
	a_tog_rise: assert property (p_tog_rise) else $error("toggle set while idle");
	property p_tog_hold; float_overflow_toggle && !ovf_clear |=> float_overflow_toggle; endproperty
	a_tog_hold: assert property (p_tog_hold) else $error("overflow toggle lost");
	property p_tog_clear; ovf_clear && !busy && !take |=> !float_overflow_toggle; endproperty
	a_tog_clear: assert property (p_tog_clear) else $error("overflow toggle not cleared");
	property p_done_bound; $rose(busy) |-> ##[3:300] done; endproperty
	a_done_bound: assert property (p_done_bound) else $error("operation did not complete");
	property p_done_once; done |=> !done; endproperty
	a_done_once: assert property (p_done_once) else $error("done longer than one cycle");

	c_norm: cover property (done && sv_addsub && sv_norm);
	c_mul: cover property (done && sv_op == dfp_pkg::OP_MUL);
	c_wrap: cover property ($rose(float_overflow_toggle));
endmodule

bind dfp_float_unit dfp_float_unit_checker chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
	.start(start), .op(op), .normalize_select_bit(normalize_select_bit),
	.float_select_bit(float_select_bit), .mem_word(mem_word), .acc_load(acc_load),
	.acc_in(acc_in), .ovf_clear(ovf_clear), .acc_word(acc_word), .aux_word(aux_word),
	.busy(busy), .done(done), .float_overflow_toggle(float_overflow_toggle));

// *** sim/dfp_seq_model.sv ***
// Purpose: Instruction sequencer and memory read side feeding the float unit
// Assumes: Requests come as a one-cycle req pulse with fields held afterwards
// Notes: gap delays the start pulse to mimic a slow memory cycle
`timescale 1ns/1ps
module dfp_seq_model (
	input wire logic clk_sys,
	input wire logic req,
	input wire logic [1:0] req_op,
	input wire logic req_norm,
	input wire logic req_fsel,
	input wire dfp_pkg::dfp_word_t req_word,
	input wire logic [3:0] gap,
	output logic start = 1'b0,
	output logic [1:0] op = 2'h0,
	output logic normalize_select_bit = 1'b0,
	output logic float_select_bit = 1'b0,
	output dfp_pkg::dfp_word_t mem_word = '0
);
	logic pend = 1'b0;
	logic [3:0] wait_n = 4'h0;
	wire issue_now = pend && !req && wait_n == 4'h0;

	// Operand lines show junk outside the start cycle, so a late sample shows up
	always @(negedge clk_sys) begin
		start <= issue_now;
		if (req) begin
			pend <= 1'b1;
			wait_n <= gap;
		end else if (issue_now) begin
			pend <= 1'b0;
		end else if (pend) begin
			wait_n <= wait_n - 4'h1;
		end
		if (issue_now) begin
			op <= req_op;
			normalize_select_bit <= req_norm;
			float_select_bit <= req_fsel;
			mem_word <= req_word;
		end else begin
			mem_word <= ~mem_word;
		end
	end
endmodule

// *** sim/test_decimal_float_add_sub_unit.sv ***
// Purpose: Self-checking bench for the decimal float unit
// Assumes: Inputs change on the falling edge; results read after done
// Notes: Expected words are worked out by hand in decimal
`timescale 1ns/1ps
module test_decimal_float_add_sub_unit;
	localparam logic [5:0] KA = 6'h2A;
	localparam logic [5:0] KM = 6'h15;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic acc_load = 1'b0;
	logic ovf_clear = 1'b0;
	dfp_pkg::dfp_word_t acc_in = '0;
	logic req = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic req_norm = 1'b0;
	logic req_fsel = 1'b0;
	dfp_pkg::dfp_word_t req_word = '0;
	logic [3:0] gap = 4'h0;
	logic start;
	logic [1:0] op;
	logic nsel;
	logic fsel;
	dfp_pkg::dfp_word_t mem_word;
	dfp_pkg::dfp_word_t acc_word;
	dfp_pkg::dfp_word_t aux_word;
	logic busy;
	logic done;
	logic tog;
	int err_count = 0;
	int n_compared = 0;

	always #5 clk_sys = ~clk_sys;

	dfp_seq_model seq (.clk_sys(clk_sys), .req(req), .req_op(req_op), .req_norm(req_norm),
		.req_fsel(req_fsel), .req_word(req_word), .gap(gap), .start(start), .op(op),
		.normalize_select_bit(nsel), .float_select_bit(fsel), .mem_word(mem_word));
	dfp_float_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .op(op),
		.normalize_select_bit(nsel), .float_select_bit(fsel), .mem_word(mem_word),
		.acc_load(acc_load), .acc_in(acc_in), .ovf_clear(ovf_clear), .acc_word(acc_word),
		.aux_word(aux_word), .busy(busy), .done(done), .float_overflow_toggle(tog));

	function automatic logic [47:0] w(input logic [5:0] k, input int es, input logic [7:0] e,
		input int fs, input logic [31:0] f);
		return {k, 1'(es), e, 1'(fs), f};
	endfunction

	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", name, e, g);
			err_count++;
		end
	endtask

	task automatic load(input logic [47:0] v);
		@(negedge clk_sys);
		acc_load <= 1'b1;
		acc_in <= v;
		@(negedge clk_sys);
		acc_load <= 1'b0;
	endtask

	// Bounded wait; a done missing when wanted ends the run at once
	task automatic run(input logic [1:0] o, input logic n, input logic fs, input logic [47:0] m,
		input logic want);
		int i;
		@(negedge clk_sys);
		req <= 1'b1;
		req_op <= o;
		req_norm <= n;
		req_fsel <= fs;
		req_word <= m;
		@(negedge clk_sys);
		req <= 1'b0;
		for (i = 0; i < (want ? 400 : 60) && done !== 1'b1; i++)
			@(negedge clk_sys);
		chk("done", {47'h0, want}, {47'h0, done});
		if (want && done !== 1'b1)
			final_report();
	endtask

	task automatic one(input logic [1:0] o, input logic n, input logic [47:0] a,
		input logic [47:0] m, input logic [47:0] e);
		load(a);
		run(o, n, 1'b1, m, 1'b1);
		chk("acc", e, acc_word);
	endtask

	task automatic clear_tog;
		@(negedge clk_sys);
		ovf_clear <= 1'b1;
		@(negedge clk_sys);
		ovf_clear <= 1'b0;
		chk("toggle", 48'h0, {47'h0, tog});
	endtask

	task automatic s_reset;
		chk("acc", 48'h0, acc_word);
		chk("aux", 48'h0, aux_word);
		chk("busy", 48'h0, {47'h0, busy});
		chk("toggle", 48'h0, {47'h0, tog});
	endtask

	task automatic s_add_like;
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 1, 8'h00, 0, 32'h12345678),
			w(KM, 0, 8'h00, 0, 32'h11111111), w(KA, 0, 8'h00, 0, 32'h23456789));
		chk("aux", w(KM, 0, 8'h00, 0, 32'h11111111), aux_word);
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h05, 0, 32'h90000000),
			w(KM, 0, 8'h05, 0, 32'h20000000), w(KA, 0, 8'h06, 0, 32'h11000000));
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h03, 0, 32'h10000000),
			w(KM, 0, 8'h02, 0, 32'h12345678), w(KA, 0, 8'h03, 0, 32'h11234568));
	endtask

	// Slow sequencer here to vary the start timing
	task automatic s_far;
		gap = 4'h3;
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h00, 0, 32'h11111111),
			w(KM, 0, 8'h09, 0, 32'h22222222), w(KA, 0, 8'h09, 0, 32'h22222222));
		one(dfp_pkg::OP_SUB, 1'b0, w(KA, 0, 8'h00, 0, 32'h11111111),
			w(KM, 0, 8'h09, 0, 32'h22222222), w(KA, 0, 8'h09, 1, 32'h22222222));
		gap = 4'h0;
	endtask

	task automatic s_signs;
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h00, 0, 32'h10000000),
			w(KM, 0, 8'h00, 1, 32'h30000000), w(KA, 0, 8'h00, 1, 32'h20000000));
		one(dfp_pkg::OP_SUB, 1'b0, w(KA, 0, 8'h00, 0, 32'h50000000),
			w(KM, 0, 8'h00, 0, 32'h20000000), w(KA, 0, 8'h00, 0, 32'h30000000));
		one(dfp_pkg::OP_SUB, 1'b0, w(KA, 0, 8'h00, 0, 32'h50000000),
			w(KM, 0, 8'h00, 1, 32'h20000000), w(KA, 0, 8'h00, 0, 32'h70000000));
	endtask

	task automatic s_norm;
		one(dfp_pkg::OP_ADD, 1'b1, w(KA, 0, 8'h05, 0, 32'h00120000),
			w(KM, 0, 8'h03, 0, 32'h0), w(KA, 0, 8'h03, 0, 32'h12000000));
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h05, 0, 32'h00120000),
			w(KM, 0, 8'h03, 0, 32'h0), w(KA, 0, 8'h05, 0, 32'h00120000));
		one(dfp_pkg::OP_ADD, 1'b1, w(KA, 0, 8'h10, 0, 32'h00001000),
			w(KM, 0, 8'h00, 0, 32'h10000000), w(KA, 0, 8'h06, 0, 32'h10000010));
		one(dfp_pkg::OP_SUB, 1'b1, w(KA, 0, 8'h01, 0, 32'h50000000),
			w(KM, 0, 8'h01, 0, 32'h50000000), w(KA, 1, 8'h99, 0, 32'h0));
	endtask

	task automatic s_wrap;
		one(dfp_pkg::OP_ADD, 1'b0, w(KA, 0, 8'h99, 0, 32'h90000000),
			w(KM, 0, 8'h99, 0, 32'h20000000), w(KA, 1, 8'h99, 0, 32'h11000000));
		chk("toggle", 48'h1, {47'h0, tog});
		clear_tog();
		one(dfp_pkg::OP_ADD, 1'b1, w(KA, 1, 8'h99, 0, 32'h01000000),
			w(KM, 0, 8'h00, 0, 32'h0), w(KA, 0, 8'h99, 0, 32'h10000000));
		chk("toggle", 48'h1, {47'h0, tog});
		clear_tog();
	endtask

	task automatic s_ignored;
		load(w(KA, 0, 8'h01, 0, 32'h12345678));
		run(dfp_pkg::OP_ADD, 1'b0, 1'b0, w(KM, 0, 8'h01, 0, 32'h11111111), 1'b0);
		chk("acc", w(KA, 0, 8'h01, 0, 32'h12345678), acc_word);
		chk("busy", 48'h0, {47'h0, busy});
	endtask

	// Keep bits are not defined for these, so only the number part is compared
	task automatic s_muldiv;
		load(w(KA, 0, 8'h02, 0, 32'h20000000));
		run(dfp_pkg::OP_MUL, 1'b0, 1'b1, w(KM, 0, 8'h03, 1, 32'h30000000), 1'b1);
		chk("acc", w(6'h00, 0, 8'h05, 1, 32'h06000000), {6'h00, acc_word[41:0]});
		chk("aux", w(6'h00, 1, 8'h03, 1, 32'h0), {6'h00, aux_word[41:0]});
		run(dfp_pkg::OP_DIV, 1'b0, 1'b1, w(KM, 0, 8'h03, 1, 32'h30000000), 1'b1);
		// Negative over negative: quotient and remainder both positive
		chk("acc", w(6'h00, 0, 8'h02, 0, 32'h20000000), {6'h00, acc_word[41:0]});
		chk("aux", w(6'h00, 1, 8'h06, 0, 32'h0), {6'h00, aux_word[41:0]});
	endtask

	initial begin
		repeat (5) @(negedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		s_reset();
		s_add_like();
		s_far();
		s_signs();
		s_norm();
		s_wrap();
		s_ignored();
		s_muldiv();
		final_report();
	end
endmodule
